/* File: fsims_regs.svh */
/*
 * register offsets, field positions, reset values and timing figures of the
 * fail-safe interrupt inhibit and fail-safe state registers.
 * assumes: included by bare name from the package and the design modules.
 */
`ifndef FSIMS_REGS_SVH
`define FSIMS_REGS_SVH

// ------------------------------------------------------------
// register selectors on the word access port
// ------------------------------------------------------------
`define FSIMS_ADDR_W             6
`define FSIMS_ADDR_INHIBIT       6'h16
`define FSIMS_ADDR_STATE         6'h17
`define FSIMS_DATA_W             24

// ------------------------------------------------------------
// interrupt inhibit fields (source index 0 = bit 8 .. 9 = bit 17)
// ------------------------------------------------------------
`define FSIMS_INH_LSB            8
`define FSIMS_INH_MSB            17
`define FSIMS_NUM_SRC            10
`define FSIMS_INH_RESET          10'h000

// ------------------------------------------------------------
// fail-safe state fields
// ------------------------------------------------------------
`define FSIMS_LEAVE_DBG_BIT      22
`define FSIMS_DBG_ACTIVE_BIT     21
`define FSIMS_FUSE_CRC_BIT       19
`define FSIMS_INIT_MISMATCH_BIT  16
`define FSIMS_STATE_LSB          8
`define FSIMS_STATE_MSB          12
`define FSIMS_CODE_INIT          5'h06
`define FSIMS_CODE_WAIT_ST2      5'h07
`define FSIMS_CODE_ST2           5'h08
`define FSIMS_CODE_ASSERT_SAFE   5'h09
`define FSIMS_CODE_NORMAL        5'h0a

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define FSIMS_CLK_HZ             25000000
`define FSIMS_FUSE_CHECK_MS      5

`endif

/* File: fsims_pkg.sv */
/*
 * types of the fail-safe interrupt inhibit and state register bank.
 * assumes: fsims_regs.svh is on the include path.
 */
package fsims_pkg;
`include "fsims_regs.svh"

    // fail-safe state machine codes as reported in the state register
    typedef enum logic [4:0] {
        FSIMS_SAFETY_INIT_STATE        = `FSIMS_CODE_INIT,
        FSIMS_AWAIT_SELFTEST2_STATE    = `FSIMS_CODE_WAIT_ST2,
        FSIMS_SELFTEST2_STATE          = `FSIMS_CODE_ST2,
        FSIMS_ASSERT_SAFE_OUTPUT_STATE = `FSIMS_CODE_ASSERT_SAFE,
        FSIMS_SAFETY_NORMAL_STATE      = `FSIMS_CODE_NORMAL
    } fsims_state_t;

    typedef logic [`FSIMS_NUM_SRC-1:0] fsims_src_t;

endpackage

/* File: fsims_tick.sv */
/*
 * periodic one-cycle enable that paces the fuse configuration crc check.
 * assumes: one clock, synchronous active-low reset.
 */
`timescale 1ns/100ps

module fsims_tick #(
    parameter int unsigned PERIOD = 125000
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic nrst,
    // periodic enable
    output logic      tick
);
    import fsims_pkg::*;

    localparam int unsigned CW = (PERIOD > 1) ? $clog2(PERIOD) : 1;
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

    logic [CW-1:0] cnt_r;
    logic          tick_r;
    wire           wrap = (cnt_r == LAST);

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end else begin
            cnt_r  <= wrap ? '0 : cnt_r + 1'b1;
            tick_r <= wrap;
        end
    end

    assign tick = tick_r;

endmodule

/* File: fsims_bank.sv */
/*
 * fail-safe interrupt inhibit register and fail-safe state register, with
 * event gating onto the active-low interrupt output, debug exit, fuse crc
 * and init shadow corruption flags, and the state code readback.
 * assumes: word accesses come from the fail-safe serial frame decoder on
 * clk_sys; event sources and the fail-safe state machine are on clk_sys;
 * the error monitor and fault inputs are pins from outside.
 */
// Behaviour
// RULE1: inhibit bit 17 decides whether fourth voltage monitor events may drive the interrupt low.
// RULE2: inhibit bit 16 decides whether third voltage monitor events may drive the interrupt low.
// RULE3: inhibit bits 15 and 14 gate second and first voltage monitor events.
// RULE4: inhibit bits 13 and 12 gate io supply and core supply monitor events.
// RULE5: inhibit bit 11 gates bad watchdog refresh events.
// RULE6: inhibit bits 10, 9 and 8 gate error pin, second and first fault input events.
// RULE7: an inhibit bit at 0 lets its source interrupt, at 1 it blocks it, and all clear at reset.
// RULE8: writing 1 to bit 22 leaves debug mode, 0 does nothing, and bit 21 shows live debug state.
// RULE9: the fuse configuration is crc checked every 5 ms and bit 19 is set on error.
// RULE10: init registers are compared against their inverted shadow always and bit 16 is set on mismatch.
// RULE11: both corruption flags clear at reset and clear on a write of 1, a write of 0 keeps them.
// RULE12: bits 12 to 8 read the current fail-safe state code, 00110 after reset.
// RULE13: software writes zero to reserved and read-only positions and ignores reserved reads.
// RULE14: the interrupt goes low only for unmasked events, while every event still reaches status.
`timescale 1ns/100ps
`include "fsims_regs.svh"

module fsims_bank #(
    parameter int unsigned INIT_BITS      = 16,
    parameter int unsigned FUSE_CHECK_CYC = (`FSIMS_FUSE_CHECK_MS * (`FSIMS_CLK_HZ / 1000))
) (
    // clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          nrst,
    // register word access
    input  wire logic                          reg_wr_en,
    input  wire logic                          reg_rd_en,
    input  wire logic [`FSIMS_ADDR_W-1:0]      reg_addr,
    input  wire logic [`FSIMS_DATA_W-1:0]      reg_wdata,
    output logic      [`FSIMS_DATA_W-1:0]      reg_rdata,
    output logic                               reg_rd_valid,
    output logic                               reg_addr_err,
    // same-clock event pulses
    input  wire logic [3:0]                    monitor_event,
    input  wire logic                          io_supply_event,
    input  wire logic                          core_supply_event,
    input  wire logic                          bad_refresh_event,
    // pins from outside
    input  wire logic                          error_monitor_pin,
    input  wire logic                          fault_input_1,
    input  wire logic                          fault_input_2,
    // debug mode and state machine
    input  wire logic                          debug_entry,
    input  wire fsims_pkg::fsims_state_t       safety_state_code,
    // fuse crc checker
    input  wire logic                          fuse_check_done,
    input  wire logic                          fuse_check_bad,
    // init registers and inverted shadows
    input  wire logic [INIT_BITS-1:0]          init_cfg,
    input  wire logic [INIT_BITS-1:0]          init_cfg_inv,
    // outputs
    output logic                               interrupt_out_n,
    output fsims_pkg::fsims_src_t              event_seen,
    output logic                               fuse_check_start,
    output logic                               debug_active_flag
);
    import fsims_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers and edge detection
    // ------------------------------------------------------------
    logic [2:0] pin_meta_r;
    logic [2:0] pin_sync_r;
    logic [2:0] pin_prev_r;
    wire  [2:0] pin_raw  = {error_monitor_pin, fault_input_2, fault_input_1};
    wire  [2:0] pin_rise = pin_sync_r & ~pin_prev_r;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pin_meta_r <= 3'h0;
            pin_sync_r <= 3'h0;
            pin_prev_r <= 3'h0;
        end else begin
            pin_meta_r <= pin_raw;
            pin_sync_r <= pin_meta_r;
            pin_prev_r <= pin_sync_r;
        end
    end

    // ------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------
    wire sel_inh   = (reg_addr == `FSIMS_ADDR_INHIBIT);
    wire sel_state = (reg_addr == `FSIMS_ADDR_STATE);
    wire wr_inh    = reg_wr_en & sel_inh;
    wire wr_state  = reg_wr_en & sel_state;
    wire acc_bad   = (reg_wr_en | reg_rd_en) & ~sel_inh & ~sel_state;

    // ------------------------------------------------------------
    // interrupt inhibit register and event gating
    // ------------------------------------------------------------
    fsims_src_t inh_r;
    fsims_src_t inh_nxt;
    fsims_src_t ev_all;
    fsims_src_t ev_pass;
    logic       int_n_r;
    fsims_src_t seen_r;

    // only bits 17..8 are stored; reserved writes are dropped
    assign inh_nxt = wr_inh ? reg_wdata[`FSIMS_INH_MSB:`FSIMS_INH_LSB] : inh_r;
    assign ev_all  = {monitor_event, io_supply_event, core_supply_event, bad_refresh_event, pin_rise};

    genvar gi;
    generate
        for (gi = 0; gi < `FSIMS_NUM_SRC; gi++) begin : g_gate
            // a set inhibit bit blocks its source; 0 lets it through (see RULE7)
            assign ev_pass[gi] = ev_all[gi] & ~inh_r[gi]; // see RULE1 see RULE2 see RULE3 see RULE4 see RULE5 see RULE6
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            inh_r   <= `FSIMS_INH_RESET; // see RULE7
            int_n_r <= 1'b1;
            seen_r  <= '0;
        end else begin
            inh_r   <= inh_nxt;
            int_n_r <= ~(|ev_pass); // see RULE14
            seen_r  <= ev_all; // see RULE14
        end
    end

    // ------------------------------------------------------------
    // debug mode
    // ------------------------------------------------------------
    logic dbg_r;
    logic dbg_nxt;
    wire  leave_debug_request = wr_state & reg_wdata[`FSIMS_LEAVE_DBG_BIT];

    // entry in the same cycle as an exit request wins
    assign dbg_nxt = debug_entry | (dbg_r & ~leave_debug_request); // see RULE8

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            dbg_r <= 1'b0;
        end else begin
            dbg_r <= dbg_nxt;
        end
    end

    // ------------------------------------------------------------
    // fuse crc pacing and corruption flags
    // ------------------------------------------------------------
    logic check_tick;
    logic start_r;
    logic fuse_err_r;
    logic fuse_err_nxt;
    logic mism_r;
    logic mism_nxt;
    logic mism_seen_r;

    fsims_tick #(
        .PERIOD (FUSE_CHECK_CYC)
    ) u_tick (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .tick    (check_tick)
    );

    wire fuse_set   = fuse_check_done & fuse_check_bad;
    wire fuse_clr   = wr_state & reg_wdata[`FSIMS_FUSE_CRC_BIT];
    wire mism_clr   = wr_state & reg_wdata[`FSIMS_INIT_MISMATCH_BIT];
    wire init_bad   = ~(&(init_cfg ^ init_cfg_inv));

    // set wins over a clear in the same cycle
    assign fuse_err_nxt = fuse_set | (fuse_err_r & ~fuse_clr); // see RULE9 see RULE11
    assign mism_nxt     = mism_seen_r | (mism_r & ~mism_clr); // see RULE10 see RULE11

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            start_r     <= 1'b0;
            fuse_err_r  <= 1'b0;
            mism_seen_r <= 1'b0;
            mism_r      <= 1'b0;
        end else begin
            start_r     <= check_tick; // see RULE9
            fuse_err_r  <= fuse_err_nxt;
            mism_seen_r <= init_bad; // see RULE10
            mism_r      <= mism_nxt;
        end
    end

    // ------------------------------------------------------------
    // state code and readback
    // ------------------------------------------------------------
    fsims_state_t state_r;
    logic [`FSIMS_DATA_W-1:0] rdata_r;
    logic                     rd_valid_r;
    logic                     addr_err_r;
    logic [`FSIMS_DATA_W-1:0] inh_word;
    logic [`FSIMS_DATA_W-1:0] state_word;
    logic [`FSIMS_DATA_W-1:0] rd_word;

    // reserved positions read as zero
    assign inh_word   = {6'h00, inh_r, 8'h00};
    assign state_word = {2'h0, dbg_r, 1'b0, fuse_err_r, 2'h0, mism_r, 3'h0, state_r, 8'h00}; // see RULE8 see RULE12
    assign rd_word    = sel_inh ? inh_word : (sel_state ? state_word : 24'h00_0000);

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_r    <= FSIMS_SAFETY_INIT_STATE; // see RULE12
            rdata_r    <= 24'h00_0000;
            rd_valid_r <= 1'b0;
            addr_err_r <= 1'b0;
        end else begin
            state_r    <= safety_state_code; // see RULE12
            rdata_r    <= reg_rd_en ? rd_word : rdata_r;
            rd_valid_r <= reg_rd_en;
            addr_err_r <= acc_bad;
        end
    end

    assign reg_rdata         = rdata_r;
    assign reg_rd_valid      = rd_valid_r;
    assign reg_addr_err      = addr_err_r;
    assign interrupt_out_n   = int_n_r;
    assign event_seen        = seen_r;
    assign fuse_check_start  = start_r;
    assign debug_active_flag = dbg_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence s_leave_write;
        wr_state && reg_wdata[`FSIMS_LEAVE_DBG_BIT] && !debug_entry;
    endsequence

    sequence s_inhibit_write(int idx);
        inh_r[idx] == $past(reg_wdata[`FSIMS_INH_LSB + idx]);
    endsequence

    sequence s_pin_edge(int idx);
        !pin_sync_r[idx] ##1 pin_sync_r[idx];
    endsequence

    chk_mon4_gate: assert property (ev_all[9] && !inh_r[9] |=> !interrupt_out_n) // see RULE1
        else $error("unmasked fourth monitor event did not interrupt");
    chk_mon3_mask: assert property ($onehot(ev_all) && ev_all[8] && inh_r[8] |=> interrupt_out_n) // see RULE2
        else $error("masked third monitor event interrupted");
    chk_mon21_gate: assert property ((ev_all[7] && !inh_r[7]) || (ev_all[6] && !inh_r[6]) |=> !interrupt_out_n) // see RULE3
        else $error("unmasked first or second monitor event lost");
    chk_supply_mask: assert property ($onehot(ev_all) && (ev_all[5] || ev_all[4]) && (&inh_r[5:4]) // see RULE4
        |=> interrupt_out_n)
        else $error("masked supply event interrupted");
    chk_refresh_gate: assert property (ev_all[3] && !inh_r[3] |=> !interrupt_out_n) // see RULE5
        else $error("bad refresh event did not interrupt");
    chk_pin_gate: assert property ($rose(pin_sync_r[2]) && !inh_r[2] |=> !interrupt_out_n) // see RULE6
        else $error("error pin event did not interrupt");
    chk_inh_store: assert property (wr_inh |=> s_inhibit_write(9)) // see RULE7
        else $error("inhibit bit 17 not stored");
    chk_inh_reset: assert property (disable iff (1'b0) !nrst |=> (inh_r == `FSIMS_INH_RESET)) // see RULE7
        else $error("inhibit bits not cleared by reset");
    chk_leave_debug: assert property (dbg_r ##0 s_leave_write |=> !debug_active_flag) // see RULE8
        else $error("debug mode not left on write of 1");
    chk_debug_keep: assert property (dbg_r && !leave_debug_request |=> debug_active_flag) // see RULE8
        else $error("debug mode dropped without request");
    chk_fuse_pace: assert property (check_tick |=> fuse_check_start ##1 !fuse_check_start) // see RULE9
        else $error("fuse check start not a single pulse");
    chk_fuse_set: assert property (fuse_set |=> fuse_err_r) // see RULE9
        else $error("fuse crc error not flagged");
    chk_mismatch_set: assert property (init_bad |-> ##2 mism_r) // see RULE10
        else $error("init mismatch not flagged in two cycles");
    chk_flag_clear: assert property (fuse_err_r && fuse_clr && !fuse_set |=> !fuse_err_r) // see RULE11
        else $error("fuse flag not cleared by write of 1");
    chk_flag_hold: assert property (mism_r && !mism_clr |=> mism_r) // see RULE11
        else $error("mismatch flag lost without clear");
    chk_state_reset: assert property (disable iff (1'b0) !nrst |=> (state_r == FSIMS_SAFETY_INIT_STATE)) // see RULE12
        else $error("state code not init after reset");
    chk_state_track: assert property (##1 (state_r == $past(safety_state_code))) // see RULE12
        else $error("state code not tracking state machine");
    chk_masked_quiet: assert property ((ev_all & ~inh_r) == '0 // see RULE14
        |=> interrupt_out_n && (event_seen == $past(ev_all)))
        else $error("interrupt without unmasked event or status lost");

    // ------------------------------------------------------------
    // opposite polarity per source and flag retention
    // ------------------------------------------------------------
    chk_mon4_mask: assert property ($onehot(ev_all) && ev_all[9] && inh_r[9] |=> interrupt_out_n) // see RULE1
        else $error("masked fourth monitor event interrupted");
    chk_mon3_gate: assert property (ev_all[8] && !inh_r[8] |=> !interrupt_out_n) // see RULE2
        else $error("unmasked third monitor event lost");
    chk_supply_gate: assert property ((ev_all[5] && !inh_r[5]) || (ev_all[4] && !inh_r[4]) // see RULE4
        |=> !interrupt_out_n) else $error("unmasked supply event lost");
    chk_refresh_mask: assert property ($onehot(ev_all) && ev_all[3] && inh_r[3] |=> interrupt_out_n) // see RULE5
        else $error("masked bad refresh event interrupted");
    chk_fault_gate: assert property (s_pin_edge(1) ##0 !inh_r[1] |=> !interrupt_out_n) // see RULE6
        else $error("second fault input event did not interrupt");
    chk_fault_mask: assert property (s_pin_edge(0) ##0 inh_r[0] ##0 $onehot(ev_all) |=> interrupt_out_n) // see RULE6
        else $error("masked first fault input event interrupted");
    chk_inh_hold: assert property (!wr_inh |=> (inh_r == $past(inh_r))) // see RULE7
        else $error("inhibit bits changed without write");
    chk_debug_entry: assert property (debug_entry |=> debug_active_flag) // see RULE8
        else $error("debug entry not shown");
    chk_fuse_hold: assert property (fuse_err_r && !fuse_clr |=> fuse_err_r) // see RULE11
        else $error("fuse flag lost without clear");
    chk_mism_clear: assert property (mism_r && mism_clr && !mism_seen_r |=> !mism_r) // see RULE11
        else $error("mismatch flag not cleared by write of 1");

endmodule

/* File: fsims_mcu.sv */
/*
 * partner model: microcontroller software reaching the register bank by
 * single word writes and reads.
 * assumes: one clock; the bench calls wr and rd hierarchically just after a
 * rising edge of clk_sys.
 */
`timescale 1ns/100ps
`include "fsims_regs.svh"

module fsims_mcu (
    // clock
    input  wire logic                     clk_sys,
    // word access towards the bank
    output logic                          reg_wr_en,
    output logic                          reg_rd_en,
    output logic [`FSIMS_ADDR_W-1:0]      reg_addr,
    output logic [`FSIMS_DATA_W-1:0]      reg_wdata,
    // answer from the bank
    input  wire logic [`FSIMS_DATA_W-1:0] reg_rdata,
    input  wire logic                     reg_rd_valid,
    input  wire logic                     reg_addr_err
);
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr  = 6'h3f;
        reg_wdata = 24'h55_aaaa;
    end

    // software keeps reserved and read-only positions at zero
    task automatic wr(input logic [5:0] a, input logic [23:0] d);
        logic [23:0] dm;
        dm = d;
        if (a == `FSIMS_ADDR_INHIBIT) dm = d & 24'h03_ff00;
        if (a == `FSIMS_ADDR_STATE) dm = d & 24'h49_0000;
        @(posedge clk_sys);
        reg_wr_en <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= dm;
        @(posedge clk_sys);
        reg_wr_en <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~dm;
    endtask

    task automatic rd(input logic [5:0] a, output logic [23:0] d, output logic v, output logic e);
        @(posedge clk_sys);
        reg_rd_en <= 1'b1;
        reg_addr  <= a;
        @(posedge clk_sys);
        reg_rd_en <= 1'b0;
        reg_addr  <= ~a;
        #1;
        d = reg_rdata;
        v = reg_rd_valid;
        e = reg_addr_err;
    endtask
endmodule

/* File: fsims_bank_tb.sv */
/*
 * self-checking bench for the fail-safe inhibit and state register bank.
 * assumes: fsims_pkg and fsims_mcu compiled first; shortened fuse period.
 */
`timescale 1ns/100ps
`include "fsims_regs.svh"

module fsims_bank_tb;
    import fsims_pkg::*;
    localparam int FUSE_CYC = 20;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic reg_wr_en, reg_rd_en, reg_rd_valid, reg_addr_err;
    logic [5:0] reg_addr;
    logic [23:0] reg_wdata, reg_rdata;
    logic [9:0] ev = 10'h000;
    logic [3:0] monitor_event;
    logic io_supply_event, core_supply_event, bad_refresh_event;
    logic error_monitor_pin, fault_input_1, fault_input_2;
    logic debug_entry = 1'b0;
    fsims_state_t safety_state_code = FSIMS_SAFETY_INIT_STATE;
    logic fuse_check_done = 1'b0;
    logic fuse_check_bad = 1'b0;
    logic [15:0] init_cfg = 16'h3c5a;
    logic [15:0] init_cfg_inv = 16'hc3a5;
    logic interrupt_out_n, fuse_check_start, debug_active_flag;
    fsims_src_t event_seen;
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [23:0] d;
    logic v, e;

    assign {monitor_event, io_supply_event, core_supply_event, bad_refresh_event,
            error_monitor_pin, fault_input_2, fault_input_1} = ev;
    always #20 clk_sys = ~clk_sys;

    fsims_bank #(.FUSE_CHECK_CYC(FUSE_CYC)) fsims_bank_inst (
        .clk_sys(clk_sys), .nrst(nrst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rd_valid(reg_rd_valid), .reg_addr_err(reg_addr_err), .monitor_event(monitor_event),
        .io_supply_event(io_supply_event), .core_supply_event(core_supply_event),
        .bad_refresh_event(bad_refresh_event), .error_monitor_pin(error_monitor_pin),
        .fault_input_1(fault_input_1), .fault_input_2(fault_input_2), .debug_entry(debug_entry),
        .safety_state_code(safety_state_code), .fuse_check_done(fuse_check_done),
        .fuse_check_bad(fuse_check_bad), .init_cfg(init_cfg), .init_cfg_inv(init_cfg_inv),
        .interrupt_out_n(interrupt_out_n), .event_seen(event_seen),
        .fuse_check_start(fuse_check_start), .debug_active_flag(debug_active_flag));

    fsims_mcu fsims_mcu_inst (
        .clk_sys(clk_sys), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
        .reg_addr_err(reg_addr_err));

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // read a register and compare the whole word
    task automatic rdchk(input string nm, input logic [5:0] a, input logic [23:0] exp);
        fsims_mcu_inst.rd(a, d, v, e);
        chk({nm, " valid"}, 24'h00_0001, {23'h0, v});
        chk(nm, exp, d);
    endtask

    // pulse one event source and watch the interrupt and the event copy
    task automatic fire(input int i, input logic masked);
        logic lo, seen;
        lo = 1'b0;
        seen = 1'b0;
        @(posedge clk_sys);
        ev <= 10'h001 << i;
        @(posedge clk_sys);
        ev <= 10'h000;
        for (int k = 0; k < 6; k++) begin
            #1;
            if (interrupt_out_n === 1'b0) lo = 1'b1;
            if (event_seen[i] === 1'b1) seen = 1'b1;
            @(posedge clk_sys);
        end
        chk("interrupt low", {23'h0, ~masked}, {23'h0, lo});
        chk("event seen", 24'h00_0001, {23'h0, seen});
    endtask

    task automatic test_reset;
        rdchk("inhibit reset", `FSIMS_ADDR_INHIBIT, 24'h00_0000);
        rdchk("state reset", `FSIMS_ADDR_STATE, 24'h00_0600);
        $display("test reset done");
    endtask

    task automatic test_masks;
        for (int i = 0; i < 10; i++) begin
            fsims_mcu_inst.wr(`FSIMS_ADDR_INHIBIT, ~(24'h00_0100 << i));
            rdchk("inhibit others", `FSIMS_ADDR_INHIBIT, 24'h03_ff00 & ~(24'h00_0100 << i));
            fire(i, 1'b0);
            fsims_mcu_inst.wr(`FSIMS_ADDR_INHIBIT, 24'h00_0100 << i);
            fire(i, 1'b1);
        end
        fsims_mcu_inst.wr(`FSIMS_ADDR_INHIBIT, 24'h00_0000);
        $display("test masks done");
    endtask

    task automatic test_state;
        fsims_state_t codes [5];
        codes = '{FSIMS_AWAIT_SELFTEST2_STATE, FSIMS_SELFTEST2_STATE,
                  FSIMS_ASSERT_SAFE_OUTPUT_STATE, FSIMS_SAFETY_NORMAL_STATE, FSIMS_SAFETY_INIT_STATE};
        foreach (codes[i]) begin
            @(posedge clk_sys);
            safety_state_code <= codes[i];
            fsims_mcu_inst.wr(`FSIMS_ADDR_STATE, 24'hff_ffff);
            rdchk("state code", `FSIMS_ADDR_STATE, {11'h0, 5'(codes[i]), 8'h00});
        end
        $display("test state done");
    endtask

    task automatic test_debug;
        @(posedge clk_sys);
        debug_entry <= 1'b1;
        @(posedge clk_sys);
        debug_entry <= 1'b0;
        #1;
        chk("debug flag", 24'h00_0001, {23'h0, debug_active_flag});
        fsims_mcu_inst.wr(`FSIMS_ADDR_STATE, 24'h00_0000);
        rdchk("debug kept", `FSIMS_ADDR_STATE, 24'h20_0600);
        fsims_mcu_inst.wr(`FSIMS_ADDR_STATE, 24'h40_0000);
        rdchk("debug left", `FSIMS_ADDR_STATE, 24'h00_0600);
        $display("test debug done");
    endtask

    task automatic test_flags;
        int gap;
        @(posedge clk_sys);
        fuse_check_done <= 1'b1;
        fuse_check_bad <= 1'b1;
        init_cfg_inv <= 16'hc3a4;
        @(posedge clk_sys);
        fuse_check_done <= 1'b0;
        fuse_check_bad <= 1'b0;
        init_cfg_inv <= 16'hc3a5;
        repeat (3) @(posedge clk_sys);
        fsims_mcu_inst.wr(`FSIMS_ADDR_STATE, 24'h00_0000);
        rdchk("flags set", `FSIMS_ADDR_STATE, 24'h09_0600);
        fsims_mcu_inst.wr(`FSIMS_ADDR_STATE, 24'h08_0000);
        rdchk("crc cleared", `FSIMS_ADDR_STATE, 24'h01_0600);
        fsims_mcu_inst.wr(`FSIMS_ADDR_STATE, 24'h01_0000);
        rdchk("mismatch cleared", `FSIMS_ADDR_STATE, 24'h00_0600);
        gap = 0;
        while (fuse_check_start !== 1'b1 && gap < 3 * FUSE_CYC) begin
            @(posedge clk_sys);
            #1;
            gap++;
        end
        gap = 0;
        do begin
            @(posedge clk_sys);
            #1;
            gap++;
        end while (fuse_check_start !== 1'b1 && gap < 3 * FUSE_CYC);
        chk("check period", 24'(FUSE_CYC), 24'(gap));
        $display("test flags done");
    endtask

    // reset in mid-run must clear a set inhibit word and a raised flag
    task automatic test_rerun;
        fsims_mcu_inst.wr(`FSIMS_ADDR_INHIBIT, 24'h03_ff00);
        @(posedge clk_sys);
        fuse_check_done <= 1'b1;
        fuse_check_bad <= 1'b1;
        @(posedge clk_sys);
        fuse_check_done <= 1'b0;
        fuse_check_bad <= 1'b0;
        nrst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        rdchk("inhibit rerun", `FSIMS_ADDR_INHIBIT, 24'h00_0000);
        rdchk("flags rerun", `FSIMS_ADDR_STATE, 24'h00_0600);
        $display("test rerun done");
    endtask

    task automatic test_unmapped;
        fsims_mcu_inst.wr(6'h00, 24'hff_ffff);
        fsims_mcu_inst.rd(6'h00, d, v, e);
        chk("unmapped data", 24'h00_0000, d);
        chk("unmapped error", 24'h00_0001, {23'h0, e});
        rdchk("inhibit untouched", `FSIMS_ADDR_INHIBIT, 24'h00_0000);
        $display("test unmapped done");
    endtask

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            final_report;
        end
    end

    initial begin
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        test_reset;
        test_masks;
        test_state;
        test_debug;
        test_flags;
        test_rerun;
        test_unmapped;
        final_report;
    end
endmodule
